// ==== include/port_mp_pkg.sv ====
/*
 Package for the port M / port P pin integration block: register offsets,
 reset values, pin counts and the packed carriers shared by the files.
 Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package port_mp_pkg;
	localparam int M_PINS = 4;
	localparam int P_PINS = 6;
	localparam int M_LSB = 2;

	// byte offsets of the registers
	localparam logic [7:0] OFS_M_DATA = 8'h00;
	localparam logic [7:0] OFS_M_READBACK = 8'h04;
	localparam logic [7:0] OFS_M_DIR = 8'h08;
	localparam logic [7:0] OFS_M_DRIVE = 8'h0C;
	localparam logic [7:0] OFS_M_PULL_EN = 8'h10;
	localparam logic [7:0] OFS_M_PULL_POL = 8'h14;
	localparam logic [7:0] OFS_M_OPEN_DRAIN = 8'h18;
	localparam logic [7:0] OFS_P_DATA = 8'h1C;
	localparam logic [7:0] OFS_P_READBACK = 8'h20;
	localparam logic [7:0] OFS_P_DIR = 8'h24;

	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// per-pin resolved controls toward the pad ring
	typedef struct packed {
		logic out;
		logic oe;
		logic reduced;
		logic pull_up;
		logic pull_down;
	} pad_ctl_s;

	// peripheral side of port M: two CAN controllers
	typedef struct packed {
		logic [1:0] can_enable;
		logic [1:0] can_tx;
	} can_side_s;

	// peripheral side of port P
	typedef struct packed {
		logic [5:0] pwm_enable;
		logic [5:0] pwm_out;
		logic pwm5_shutdown;
		logic i2c_enable;
		logic i2c_scl_oe;
		logic i2c_sda_oe;
		logic sci_tx_enable;
		logic sci_rx_enable;
		logic sci_tx;
	} p_side_s;

	typedef struct packed {
		logic awv;
		logic [7:0] awaddr;
		logic wv;
		logic [7:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} axi_st_s;
endpackage : port_mp_pkg

// ==== logic/pin_sync.sv ====
/*
 Three-flop input synchroniser for a group of pins; a change is taken once
 the second and third stages agree. Assumes pins are asynchronous to aclk.
*/
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} sync_st_s;
	sync_st_s st_r;
	sync_st_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.lvl[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.lvl;
endmodule : pin_sync

// ==== logic/port_mp_pins.sv ====
/*
 Pin integration for port M (four pins shared with two CAN controllers)
 and port P (six pins shared with PWM, serial and I2C), with an AXI4-Lite
 register slave. Pads are split into out, output enable and pull controls.
 Assumes the peripheral side signals are synchronous to aclk.
*/
`timescale 1ns/100ps
// Summary of operation
// - readback registers return pins, ignore writes
// - port M direction bits 5:2, 1 output
// - enabled CAN forces transmit out, receive in
// - reduced drive only on output pins
// - port M pull on inputs or open-drain
// - polarity 0 up, 1 down, input only
// - CAN-owned pins allow pull-ups only
// - wired-OR output drives low, floats high
// - wired-OR also governs CAN transmit pins
// - port P priority PWM, serial/I2C, GPIO
// - PWM forces output; channel 5 shutdown input
// - I2C takes pins 5:4 open-drain bidirectional
// - serial transmit pin 0, receive pin 2
// - port P resets to high-impedance inputs
// - port P data reads latch or pin
// - port P direction controls free pins
// - data writes store, drive only outputs
// - port M resets to high-impedance inputs
module port_mp_pins
	import port_mp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire port_mp_pkg::can_side_s can_side,
	output logic [1:0] can_rx,
	input wire port_mp_pkg::p_side_s p_side,
	output logic pwm5_in,
	output logic i2c_scl_in,
	output logic i2c_sda_in,
	output logic sci_rx,
	input wire logic [3:0] first_port_pins_in,
	output port_mp_pkg::pad_ctl_s [3:0] first_port_pins_ctl,
	input wire logic [5:0] second_port_pins_in,
	output port_mp_pkg::pad_ctl_s [5:0] second_port_pins_ctl
);
	import port_mp_pkg::*;

	typedef struct packed {
		logic [3:0] m_data;
		logic [3:0] m_dir;
		logic [3:0] m_drive;
		logic [3:0] m_pull_en;
		logic [3:0] m_pull_pol;
		logic [3:0] m_od;
		logic [5:0] p_data;
		logic [5:0] p_dir;
		logic wstrb0;
		axi_st_s axi;
		pad_ctl_s [3:0] m_pad;
		pad_ctl_s [5:0] p_pad;
		logic [1:0] can_rx;
		logic pwm5_in;
		logic scl_in;
		logic sda_in;
		logic sci_rx;
	} st_s;
	st_s st_r;
	st_s st_nxt;

	logic [3:0] m_lvl;
	logic [5:0] p_lvl;

	pin_sync #(.W(M_PINS)) u_sync_m (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(first_port_pins_in),
		.level(m_lvl)
	);

	pin_sync #(.W(P_PINS)) u_sync_p (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(second_port_pins_in),
		.level(p_lvl)
	);

	// per-pin ownership, computed combinationally from the live enables
	logic [3:0] m_own;
	logic [3:0] m_fout;
	logic [3:0] m_fdir;
	logic [5:0] p_own;
	logic [5:0] p_fout;
	logic [5:0] p_fdir;
	logic [5:0] p_fod;

	always_comb begin
		m_own = '0;
		m_fout = '0;
		m_fdir = '0;
		for (int c = 0; c < 2; c++) begin
			if (can_side.can_enable[c]) begin
				m_own[2*c+1] = 1'b1;
				m_own[2*c] = 1'b1;
				m_fdir[2*c] = 1'b1;
				m_fout[2*c] = can_side.can_tx[c];
			end
		end
	end

	always_comb begin
		p_own = '0;
		p_fout = '0;
		p_fdir = '0;
		p_fod = '0;
		if (p_side.sci_tx_enable) begin
			p_own[0] = 1'b1;
			p_fdir[0] = 1'b1;
			p_fout[0] = p_side.sci_tx;
		end
		if (p_side.sci_rx_enable) begin
			p_own[2] = 1'b1;
		end
		// I2C open-drain lines, low driven only
		if (p_side.i2c_enable) begin
			p_own[5:4] = 2'b11;
			p_fod[5:4] = 2'b11;
			p_fdir[5] = p_side.i2c_scl_oe;
			p_fdir[4] = p_side.i2c_sda_oe;
			p_fout[5:4] = 2'b00;
		end
		for (int i = 0; i < P_PINS; i++) begin
			if (p_side.pwm_enable[i]) begin
				p_own[i] = 1'b1;
				p_fod[i] = 1'b0;
				p_fdir[i] = !(i == 5 && p_side.pwm5_shutdown);
				p_fout[i] = p_side.pwm_out[i];
			end
		end
	end

	logic aw_go;
	logic w_go;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic rd_hit;
	logic wr_hit;

	always_comb begin
		st_nxt = st_r;
		aw_go = s_axi_awvalid && !st_r.axi.awv;
		w_go = s_axi_wvalid && !st_r.axi.wv;
		if (aw_go) begin
			st_nxt.axi.awv = 1'b1;
			st_nxt.axi.awaddr = s_axi_awaddr;
		end
		if (w_go) begin
			st_nxt.axi.wv = 1'b1;
			st_nxt.axi.wdata = s_axi_wdata[7:0];
			// strobe travels with the data beat; master may drop it once taken
			st_nxt.wstrb0 = s_axi_wstrb[0];
		end
		wbyte = st_r.axi.wdata;
		wr_hit = 1'b1;
		// writes act once address and data held
		if (st_r.axi.awv && st_r.axi.wv && !st_r.axi.bvalid) begin
			st_nxt.axi.awv = 1'b0;
			st_nxt.axi.wv = 1'b0;
			st_nxt.axi.bvalid = 1'b1;
			case (st_r.axi.awaddr & 8'hFC)
				OFS_M_DATA: st_nxt.m_data = wbyte[5:2];
				OFS_M_DIR: st_nxt.m_dir = wbyte[5:2];
				OFS_M_DRIVE: st_nxt.m_drive = wbyte[5:2];
				OFS_M_PULL_EN: st_nxt.m_pull_en = wbyte[5:2];
				OFS_M_PULL_POL: st_nxt.m_pull_pol = wbyte[5:2];
				OFS_M_OPEN_DRAIN: st_nxt.m_od = wbyte[5:2];
				OFS_P_DATA: st_nxt.p_data = wbyte[5:0];
				OFS_P_DIR: st_nxt.p_dir = wbyte[5:0];
				OFS_M_READBACK, OFS_P_READBACK: wr_hit = 1'b1;
				default: wr_hit = 1'b0;
			endcase
			st_nxt.axi.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
			// strobe lane 0 off: nothing stored, still answered
			if (!st_r.wstrb0) begin
				st_nxt.m_data = st_r.m_data;
				st_nxt.m_dir = st_r.m_dir;
				st_nxt.m_drive = st_r.m_drive;
				st_nxt.m_pull_en = st_r.m_pull_en;
				st_nxt.m_pull_pol = st_r.m_pull_pol;
				st_nxt.m_od = st_r.m_od;
				st_nxt.p_data = st_r.p_data;
				st_nxt.p_dir = st_r.p_dir;
			end
		end
		if (st_r.axi.bvalid && s_axi_bready) begin
			st_nxt.axi.bvalid = 1'b0;
		end
		rbyte = 8'h00;
		rd_hit = 1'b1;
		case (s_axi_araddr & 8'hFC)
			OFS_M_DATA: rbyte = {2'b00, (st_r.m_data & st_r.m_dir) | (m_lvl & ~st_r.m_dir), 2'b00};
			OFS_M_READBACK: rbyte = {2'b00, m_lvl, 2'b00};
			OFS_M_DIR: rbyte = {2'b00, st_r.m_dir, 2'b00};
			OFS_M_DRIVE: rbyte = {2'b00, st_r.m_drive, 2'b00};
			OFS_M_PULL_EN: rbyte = {2'b00, st_r.m_pull_en, 2'b00};
			OFS_M_PULL_POL: rbyte = {2'b00, st_r.m_pull_pol, 2'b00};
			OFS_M_OPEN_DRAIN: rbyte = {2'b00, st_r.m_od, 2'b00};
			// latch or pin; bits 7:6 zero
			OFS_P_DATA: rbyte = {2'b00, (st_r.p_data & st_r.p_dir) | (p_lvl & ~st_r.p_dir)};
			OFS_P_READBACK: rbyte = {2'b00, p_lvl};
			OFS_P_DIR: rbyte = {2'b00, st_r.p_dir};
			default: rd_hit = 1'b0;
		endcase
		st_nxt.axi.arready = 1'b0;
		if (s_axi_arvalid && !st_r.axi.rvalid && !st_r.axi.arready) begin
			st_nxt.axi.arready = 1'b1;
			st_nxt.axi.rvalid = 1'b1;
			st_nxt.axi.rdata = rbyte;
			st_nxt.axi.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (st_r.axi.rvalid && s_axi_rready) begin
			st_nxt.axi.rvalid = 1'b0;
		end

		for (int i = 0; i < M_PINS; i++) begin
			logic dir;
			logic od;
			dir = 1'b0;
			od = 1'b0;
			dir = m_own[i] ? m_fdir[i] : st_r.m_dir[i];
			od = st_r.m_od[i];
			st_nxt.m_pad[i].out = m_own[i] ? m_fout[i] : st_r.m_data[i];
			st_nxt.m_pad[i].oe = dir && !(od && st_nxt.m_pad[i].out);
			st_nxt.m_pad[i].reduced = dir && st_r.m_drive[i];
			st_nxt.m_pad[i].pull_up = st_r.m_pull_en[i] && (!dir || od) && !st_r.m_pull_pol[i];
			st_nxt.m_pad[i].pull_down = st_r.m_pull_en[i] && !dir && st_r.m_pull_pol[i];
			if (m_own[i]) begin
				st_nxt.m_pad[i].pull_down = 1'b0;
				st_nxt.m_pad[i].pull_up = st_r.m_pull_en[i] && (!dir || od);
			end
		end
		for (int i = 0; i < P_PINS; i++) begin
			logic dir;
			dir = 1'b0;
			dir = p_own[i] ? p_fdir[i] : st_r.p_dir[i];
			st_nxt.p_pad[i].out = p_own[i] ? p_fout[i] : st_r.p_data[i];
			st_nxt.p_pad[i].oe = dir && !(p_fod[i] && st_nxt.p_pad[i].out);
			st_nxt.p_pad[i].reduced = 1'b0;
			st_nxt.p_pad[i].pull_up = 1'b0;
			st_nxt.p_pad[i].pull_down = 1'b0;
		end
		st_nxt.can_rx[0] = m_lvl[1];
		st_nxt.can_rx[1] = m_lvl[3];
		st_nxt.pwm5_in = p_lvl[5];
		st_nxt.scl_in = p_lvl[5];
		st_nxt.sda_in = p_lvl[4];
		st_nxt.sci_rx = p_lvl[2];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// port P high-impedance inputs; port M also
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = !st_r.axi.awv;
	assign s_axi_wready = !st_r.axi.wv;
	assign s_axi_bvalid = st_r.axi.bvalid;
	assign s_axi_bresp = st_r.axi.bresp;
	assign s_axi_arready = st_r.axi.arready;
	assign s_axi_rvalid = st_r.axi.rvalid;
	assign s_axi_rdata = {24'h000000, st_r.axi.rdata};
	assign s_axi_rresp = st_r.axi.rresp;
	assign first_port_pins_ctl = st_r.m_pad;
	assign second_port_pins_ctl = st_r.p_pad;
	assign can_rx = st_r.can_rx;
	assign pwm5_in = st_r.pwm5_in;
	assign i2c_scl_in = st_r.scl_in;
	assign i2c_sda_in = st_r.sda_in;
	assign sci_rx = st_r.sci_rx;
endmodule : port_mp_pins

// ==== verif/port_mp_pins_properties.sv ====
/* Concurrent checks on the port M / port P pin block, bound to its top.
 Assumes peripheral inputs are levels on aclk and pad controls are registered. */
`timescale 1ns/100ps
module port_mp_pins_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_rvalid,
	input wire port_mp_pkg::can_side_s can_side,
	input wire port_mp_pkg::p_side_s p_side,
	input wire port_mp_pkg::pad_ctl_s [3:0] first_port_pins_ctl,
	input wire port_mp_pkg::pad_ctl_s [5:0] second_port_pins_ctl
);
	import port_mp_pkg::*;
	wire pad_ctl_s [3:0] m = first_port_pins_ctl;
	wire pad_ctl_s [5:0] p = second_port_pins_ctl;
	wire p_side_s ps = p_side;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar;
		$rose(s_axi_arvalid);
	endsequence
	a_reset_pads_idle: assert property (disable iff (1'h0) !aresetn |=>
		m == '0 && p == '0) else $error("pads not idle in reset");
	a_can_rx_in: assert property (can_side.can_enable[0] |=> !m[1].oe)
		else $error("can receive pin driven");
	a_can_no_pulldown: assert property (can_side.can_enable[1] |=>
		!m[2].pull_down && !m[3].pull_down) else $error("pull-down on can pin");
	a_pwm_drives_pin: assert property (ps.pwm_enable[3] |=>
		p[3].oe && p[3].out == $past(ps.pwm_out[3])) else $error("pwm pin not driven");
	a_pwm5_shutdown_in: assert property (ps.pwm_enable[5] && ps.pwm5_shutdown |=> !p[5].oe)
		else $error("pwm5 shutdown pin driven");
	a_i2c_open_drain: assert property (ps.i2c_enable && !ps.pwm_enable[5] |=>
		!p[5].out && p[5].oe == $past(ps.i2c_scl_oe)) else $error("clock line not open drain");
	a_sci_tx_out: assert property (ps.sci_tx_enable && !ps.pwm_enable[0] |=>
		p[0].oe && p[0].out == $past(ps.sci_tx)) else $error("serial transmit pin wrong");
	a_sci_rx_in: assert property (ps.sci_rx_enable && !ps.pwm_enable[2] |=> !p[2].oe)
		else $error("serial receive pin driven");
	a_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_read_answers: assert property (s_ar |-> ##[1:4] s_axi_rvalid)
		else $error("read not answered");
endmodule : port_mp_pins_properties
bind port_mp_pins port_mp_pins_properties chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_rvalid, .can_side, .p_side, .first_port_pins_ctl,
	.second_port_pins_ctl);

// ==== verif/periph_model.sv ====
/* On-chip peripherals and pad wires facing the pin block.
 Assumes the bench commands peripheral levels; outside world levels via ext. */
`timescale 1ns/100ps
module periph_model (
	input wire logic aclk,
	input wire port_mp_pkg::can_side_s can_cmd,
	input wire port_mp_pkg::p_side_s p_cmd,
	input wire port_mp_pkg::pad_ctl_s [3:0] first_port_pins_ctl,
	input wire port_mp_pkg::pad_ctl_s [5:0] second_port_pins_ctl,
	input wire logic [3:0] m_ext,
	input wire logic [5:0] p_ext,
	output port_mp_pkg::can_side_s can_side,
	output port_mp_pkg::p_side_s p_side,
	output logic [3:0] first_port_pins_in,
	output logic [5:0] second_port_pins_in
);
	import port_mp_pkg::*;
	initial begin
		can_side = '0;
		p_side = '0;
	end
	// peripherals launch just after the edge, like clocked logic
	always @(posedge aclk) begin
		can_side <= can_cmd;
		p_side <= p_cmd;
	end
	// a driving pad wins the wire, else the outside level shows
	always_comb begin
		for (int i = 0; i < 4; i++)
			first_port_pins_in[i] = first_port_pins_ctl[i].oe ? first_port_pins_ctl[i].out : m_ext[i];
		for (int i = 0; i < 6; i++)
			second_port_pins_in[i] = second_port_pins_ctl[i].oe ? second_port_pins_ctl[i].out : p_ext[i];
	end
endmodule : periph_model

// ==== verif/port_m_p_pin_integration_test.sv ====
/* Self-checking bench for the port M / port P pin block over AXI4-Lite.
 Assumes periph_model on the far side and a 25 MHz aclk. */
`timescale 1ns/100ps
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module port_m_p_pin_integration_test;
	import port_mp_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, rd;
	logic [3:0] s_axi_wstrb = 4'hF, m_ext = '0, first_port_pins_in;
	logic [5:0] p_ext = '0, second_port_pins_in;
	logic [1:0] rsp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, can_rx;
	wire pwm5_in, i2c_scl_in, i2c_sda_in, sci_rx;
	wire [31:0] s_axi_rdata;
	can_side_s can_cmd = '0, can_side;
	p_side_s p_cmd = '0, p_side;
	pad_ctl_s [3:0] first_port_pins_ctl, mc;
	pad_ctl_s [5:0] second_port_pins_ctl, pc;
	int checks = 0, miscompares = 0;
	logic [7:0] ofs [8] = '{OFS_M_DATA, OFS_M_DIR, OFS_M_DRIVE, OFS_M_PULL_EN, OFS_M_PULL_POL,
		OFS_M_OPEN_DRAIN, OFS_P_DATA, OFS_P_DIR};
	logic [7:0] msk [8] = '{8'h00, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h00, 8'h3F};
	assign mc = first_port_pins_ctl;
	assign pc = second_port_pins_ctl;
	initial forever #20 aclk = ~aclk;
	port_mp_pins DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .can_side, .can_rx, .p_side, .pwm5_in, .i2c_scl_in, .i2c_sda_in,
		.sci_rx, .first_port_pins_in, .first_port_pins_ctl, .second_port_pins_in,
		.second_port_pins_ctl);
	periph_model peer (.aclk, .can_cmd, .p_cmd, .first_port_pins_ctl, .second_port_pins_ctl,
		.m_ext, .p_ext, .can_side, .p_side, .first_port_pins_in, .second_port_pins_in);
	function automatic logic [5:0] oes(input pad_ctl_s [5:0] c);
		for (int i = 0; i < 6; i++) oes[i] = c[i].oe;
	endfunction : oes
	task automatic report_and_stop;
		if (miscompares == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic await(input bit ok);
		if (!ok) begin
			miscompares++;
			$display("ERROR bus wait exp 1 got 0");
			report_and_stop();
		end
	endtask : await
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad, dd, bd;
		{ad, dd, bd} = '0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int n = 0; n < 40 && !bd; n++) begin
			@(posedge aclk);
			if (s_axi_awready && !ad) begin
				ad = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wready && !dd) begin
				dd = 1;
				s_axi_wvalid <= 1'h0;
			end
			bd = s_axi_bvalid;
			rsp = s_axi_bresp;
		end
		s_axi_bready <= 1'h0;
		await(bd);
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		bit got;
		got = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			got = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
		end
		s_axi_rready <= 1'h0;
		await(got);
	endtask : rdr
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		`CK("m pads", 20'h0, mc)
		`CK("p pads", 30'h0, pc)
		foreach (ofs[i]) begin
			rdr(ofs[i]);
			`CK("reg reset", 32'h0, rd)
			wr(ofs[i], 32'hFFFF_FFFF);
			rdr(ofs[i]);
			`CK("reg mask", {24'h0, msk[i]}, rd)
			wr(ofs[i], 32'h0);
		end
		m_ext <= 4'hA;
		p_ext <= 6'h2A;
		repeat (8) @(posedge aclk);
		wr(OFS_P_READBACK, 32'hFF);
		rdr(OFS_P_READBACK);
		`CK("p readback", 32'h2A, rd)
		rdr(OFS_M_READBACK);
		`CK("m readback", 32'h28, rd)
		`CK("can rx", 2'h3, can_rx)
		`CK("far inputs", 4'hC, {pwm5_in, i2c_scl_in, i2c_sda_in, sci_rx})
		wr(OFS_P_DIR, 32'h0F);
		wr(OFS_P_DATA, 32'hFF);
		rdr(OFS_P_DATA);
		`CK("p data mixed", 32'h2F, rd)
		`CK("p oe", 6'h0F, oes(pc))
		wr(OFS_P_DIR, 32'h3F);
		repeat (8) @(posedge aclk);
		rdr(OFS_P_READBACK);
		`CK("p driven", 32'h3F, rd)
		wr(8'h40, 32'h0);
		`CK("unmapped", RESP_SLVERR, rsp)
		rdr(8'h40);
		`CK("unmapped rd", RESP_SLVERR, rsp)
		s_axi_wstrb <= 4'h0;
		wr(OFS_P_DIR, 32'h0);
		s_axi_wstrb <= 4'hF;
		`CK("no strobe resp", RESP_OKAY, rsp)
		rdr(OFS_P_DIR);
		`CK("no strobe kept", 32'h3F, rd)
		wr(OFS_M_DIR, 32'h3C);
		wr(OFS_M_DATA, 32'h14);
		wr(OFS_M_DRIVE, 32'h3C);
		repeat (3) @(posedge aclk);
		`CK("m oe", 6'h0F, oes({10'h0, mc}))
		`CK("m reduced", 1'h1, mc[1].reduced)
		wr(OFS_M_OPEN_DRAIN, 32'h3C);
		repeat (3) @(posedge aclk);
		`CK("m wired", 6'h0A, oes({10'h0, mc}))
		wr(OFS_M_DIR, 32'h0);
		wr(OFS_M_PULL_EN, 32'h3C);
		wr(OFS_M_PULL_POL, 32'h0C);
		repeat (3) @(posedge aclk);
		`CK("m reduced in", 1'h0, mc[1].reduced)
		`CK("m pull down", 1'h1, mc[0].pull_down)
		`CK("m pull up", 2'h1, {mc[3].pull_down, mc[3].pull_up})
		can_cmd <= '{can_enable: 2'h3, can_tx: 2'h0};
		repeat (3) @(posedge aclk);
		`CK("can tx oe", 1'h1, mc[0].oe)
		`CK("can rx pull", 2'h1, {mc[1].pull_down, mc[1].pull_up})
		can_cmd.can_tx <= 2'h3;
		repeat (3) @(posedge aclk);
		`CK("can tx float", 1'h0, mc[0].oe)
		can_cmd <= '0;
		repeat (3) @(posedge aclk);
		`CK("can released", 1'h1, mc[0].pull_down)
		p_cmd <= '{pwm_enable: 6'h3F, pwm_out: 6'h15, i2c_enable: 1'h1, sci_tx_enable: 1'h1,
			sci_rx_enable: 1'h1, default: 1'h0};
		repeat (3) @(posedge aclk);
		`CK("pwm oe", 6'h3F, oes(pc))
		`CK("pwm out", 1'h1, pc[4].out)
		p_cmd.pwm5_shutdown <= 1'h1;
		repeat (3) @(posedge aclk);
		`CK("pwm5 in", 1'h0, pc[5].oe)
		p_cmd.pwm_enable <= 6'h0;
		p_cmd.i2c_scl_oe <= 1'h1;
		repeat (3) @(posedge aclk);
		`CK("shared oe", 6'h2B, oes(pc))
		`CK("scl low", 1'h0, pc[5].out)
		p_cmd <= '0;
		repeat (3) @(posedge aclk);
		`CK("gpio back", 6'h3F, oes(pc))
		report_and_stop();
	end
endmodule : port_m_p_pin_integration_test
